// ### src/lamp_seq_pkg.sv
// constants, register map and state codes of the lamp start/boost/burn/hold sequencer
// assumes a single 40 MHz clock and a word-wide AHB-Lite register port
package lamp_seq_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_PERIOD = 8'h08;
  // status field positions
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_ATT_LSB = 8;
  localparam int STAT_BCNT_LSB = 10;
  localparam int STAT_RATIO_LSB = 16;
  localparam int STAT_DIM_LSB = 20;
  localparam int STAT_HOLD_BIT = 22;
  localparam int CTRL_RUN_BIT = 0;
  // reset values
  localparam logic CTRL_RUN_RST = 1'b1;
  localparam logic [15:0] PERIOD_RST = 16'h0064;
  // sequence counts
  localparam logic [3:0] PREHEAT_PULSES = 4'h8;
  localparam logic [1:0] IGN_PULSES = 2'h2;
  localparam logic [5:0] BOOST_PULSES = 6'h3f;
  localparam logic [5:0] TRANS_PULSES = 6'h20;
  localparam logic [3:0] RATIO_STEPS = 4'hf;
  localparam logic [1:0] MAX_ATTEMPTS = 2'h2;
  localparam logic [1:0] OC_EDGES = 2'h2;
  localparam logic [1:0] DIM_FULL = 2'h0;
  // frequency ratios in tenths: 2.5, 4.6, 1.8
  localparam logic [7:0] NORM_RATIO_X10 = 8'h19;
  localparam logic [7:0] BST_RATIO_X10 = 8'h2e;
  localparam logic [7:0] SHORT_RATIO_X10 = 8'h12;
  localparam logic [7:0] RATIO_DEN = 8'h0a;
  // timing
  localparam int CLK_NS = 25;
  localparam int DEAD_NS = 500;
  localparam logic [15:0] DEAD_CYC = 16'((DEAD_NS + CLK_NS - 1) / CLK_NS);
  // controller states, one-hot
  typedef enum logic [7:0] {
    ST_STARTUP = 8'h01,
    ST_PREHEAT = 8'h02,
    ST_IGNITE = 8'h04,
    ST_BOOST = 8'h08,
    ST_TRANS = 8'h10,
    ST_BURN = 8'h20,
    ST_HOLD = 8'h40,
    ST_PWRDN = 8'h80
  } state_t;
endpackage

// ### src/lamp_seq.sv
// sequencer of a lamp ballast: start-up, preheat, ignition, boost, transition, burn, hold
// assumes comparator and saw-tooth tick inputs already synchronous to clock_i;
// rst_n_i low stands for supply below the reset level
// Notes on behaviour
// - lamp ignition detected moves ignition to boost
// - boost ratio only at full brightness
// - hot-die bypass skips boost to burn
// - boost timing counts boost saw-tooth ticks
// - 63 boost ticks then automatic transition
// - 32 preheat ticks, ratio down 15 steps
// - boost end temperature starts transition now
// - shorted boost capacitor disables boost, boost limit divided by 1.8
// - boost capacitor held discharged while idle
// - burn after boost or bypass, sensing on
// - burn loop steers frequency from sense error
// - hold after failed ignition or supply stop
// - supply stop never advances attempt counter
// - hold releases on low preheat capacitor
// - hold: latch set, oscillator off, low side
// - failed ignition hold waits for ramp top
// - two saw-tooth cycles per bridge period
// - alternate switches with dead time
// - start at maximum frequency, ratio limits
// - preheat timer starts after start, eight ticks
// - ignition window two preheat timer ticks
// - continuous overcurrent timed beyond half tick
// - two ignition attempts then power-down
// - no retained memory starts at full brightness
`timescale 1ns/1ps
`default_nettype none
module lamp_seq (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire logic vdd_start_i,
  input wire logic vdd_below_stop_i,
  input wire logic cp_above_max_i,
  input wire logic cp_top_i,
  input wire logic cp_tick_i,
  input wire logic cp_release_i,
  input wire logic cp_retain_i,
  input wire logic [1:0] dim_memory_i,
  input wire logic cb_tick_i,
  input wire logic cb_short_i,
  input wire logic lamp_ignited_i,
  input wire logic temp_bypass_i,
  input wire logic temp_boost_end_i,
  input wire logic overcurrent_i,
  input wire logic current_high_i,
  output logic high_side_switch_o,
  output logic low_side_switch_o,
  output logic osc_running_o,
  output logic [3:0] boost_ratio_o,
  output logic [1:0] dim_level_o,
  output logic boost_cap_discharge_o,
  output logic preheat_timer_run_o,
  output logic preheat_cap_discharge_o,
  output logic lamp_sense_en_o,
  output logic hold_latch_o,
  output logic power_down_o
);
  // whole module state in one packed record
  typedef struct packed {
    lamp_seq_pkg::state_t st;
    logic osc_run;
    logic phase;
    logic [15:0] saw_cnt;
    logic [15:0] period;
    logic [5:0] tick_cnt;
    logic [5:0] boost_cnt;
    logic [3:0] ratio;
    logic [1:0] attempts;
    logic hold_latch;
    logic wait_top;
    logic [1:0] oc_cnt;
    logic [1:0] dim;
    logic dim_loaded;
    logic hs;
    logic ls;
    logic run_en;
    logic [15:0] min_period;
    logic [7:0] wr_addr;
    logic wr_pend;
    logic [31:0] rdata;
  } regs_t;

  regs_t s_r;
  regs_t s_nxt;
  logic bus_req;
  logic saw_end;
  logic boost_ok;
  logic [23:0] norm_lim;
  logic [23:0] bst_lim;
  logic [23:0] lim;
  logic [9:0] ratio_drop;

  assign bus_req = hsel_i & hready_i & htrans_i[1];
  assign saw_end = s_r.osc_run & (s_r.saw_cnt + 16'h0001 >= s_r.period);
  // a shorted boost capacitor or a dimmed level forbids the boost
  assign boost_ok = (s_r.dim == lamp_seq_pkg::DIM_FULL) & ~temp_bypass_i & ~cb_short_i;
  // lowest frequency as longest saw-tooth period, 24 bits to keep the products
  assign norm_lim = 24'(({8'h00, s_r.min_period} * 24'(lamp_seq_pkg::NORM_RATIO_X10))
                        / 24'(lamp_seq_pkg::RATIO_DEN));
  assign bst_lim = 24'(({8'h00, s_r.min_period} * 24'(lamp_seq_pkg::BST_RATIO_X10))
                       / 24'(lamp_seq_pkg::RATIO_DEN));
  // ratio drop after the coming transition tick, 15 steps spread over 32 ticks
  assign ratio_drop = 10'(({4'h0, s_r.tick_cnt + 6'h01} * 10'(lamp_seq_pkg::RATIO_STEPS))
                          >> 5);

  // frequency floor: boost range while boost or transition runs
  always_comb begin
    if (s_r.st == lamp_seq_pkg::ST_BOOST || s_r.st == lamp_seq_pkg::ST_TRANS) begin
      lim = bst_lim;
    end else if (cb_short_i) begin
      lim = 24'((bst_lim * 24'(lamp_seq_pkg::RATIO_DEN))
                / 24'(lamp_seq_pkg::SHORT_RATIO_X10));
    end else begin
      lim = norm_lim;
    end
  end

  // next-state logic: bus, sequencer, oscillator, gate drive
  always_comb begin
    s_nxt = s_r;
    // strap-like capture of the retained dim step, once after release
    if (!s_r.dim_loaded) begin
      s_nxt.dim_loaded = 1'b1;
      s_nxt.dim = cp_retain_i ? dim_memory_i : lamp_seq_pkg::DIM_FULL;
    end
    // data phase of a write, zero wait states
    s_nxt.wr_pend = 1'b0;
    if (s_r.wr_pend) begin
      if (s_r.wr_addr == lamp_seq_pkg::ADDR_CTRL) begin
        s_nxt.run_en = hwdata_i[lamp_seq_pkg::CTRL_RUN_BIT];
      end else if (s_r.wr_addr == lamp_seq_pkg::ADDR_PERIOD) begin
        s_nxt.min_period = hwdata_i[15:0];
      end
    end
    // oscillator saw-tooth; bridge phase flips each saw-tooth, two per period
    if (s_r.osc_run) begin
      if (saw_end) begin
        s_nxt.saw_cnt = 16'h0000;
        s_nxt.phase = ~s_r.phase;
        // raise frequency when sensed current is high, else sweep down
        if (current_high_i && s_r.period > s_r.min_period) begin
          s_nxt.period = s_r.period - 16'h0001;
        end else if (!current_high_i && {8'h00, s_r.period} < lim) begin
          s_nxt.period = s_r.period + 16'h0001;
        end
      end else begin
        s_nxt.saw_cnt = s_r.saw_cnt + 16'h0001;
      end
    end
    // controller states
    unique case (s_r.st)
      lamp_seq_pkg::ST_STARTUP: begin
        if (!s_r.osc_run && vdd_start_i && s_r.run_en) begin
          s_nxt.osc_run = 1'b1;
          s_nxt.period = s_r.min_period;
          s_nxt.saw_cnt = 16'h0000;
        end
        if (s_r.osc_run && cp_above_max_i) begin
          s_nxt.st = lamp_seq_pkg::ST_PREHEAT;
          s_nxt.tick_cnt = 6'h00;
        end
      end
      lamp_seq_pkg::ST_PREHEAT: begin
        if (vdd_below_stop_i) begin
          s_nxt.st = lamp_seq_pkg::ST_HOLD;
          s_nxt.wait_top = 1'b0;
        end else if (cp_tick_i) begin
          if (s_r.tick_cnt[3:0] + 4'h1 == lamp_seq_pkg::PREHEAT_PULSES) begin
            s_nxt.st = lamp_seq_pkg::ST_IGNITE;
            s_nxt.tick_cnt = 6'h00;
          end else begin
            s_nxt.tick_cnt = s_r.tick_cnt + 6'h01;
          end
        end
      end
      lamp_seq_pkg::ST_IGNITE: begin
        if (vdd_below_stop_i) begin
          s_nxt.st = lamp_seq_pkg::ST_HOLD;
          s_nxt.wait_top = 1'b0;
        end else if (lamp_ignited_i) begin
          s_nxt.tick_cnt = 6'h00;
          s_nxt.st = boost_ok ? lamp_seq_pkg::ST_BOOST : lamp_seq_pkg::ST_BURN;
          s_nxt.ratio = boost_ok ? lamp_seq_pkg::RATIO_STEPS : 4'h0;
        end else if (cp_tick_i) begin
          if (s_r.tick_cnt[1:0] + 2'h1 == lamp_seq_pkg::IGN_PULSES) begin
            s_nxt.attempts = s_r.attempts + 2'h1;
            if (s_r.attempts + 2'h1 == lamp_seq_pkg::MAX_ATTEMPTS) begin
              s_nxt.st = lamp_seq_pkg::ST_PWRDN;
            end else begin
              s_nxt.st = lamp_seq_pkg::ST_HOLD;
              s_nxt.wait_top = 1'b1;
            end
          end else begin
            s_nxt.tick_cnt = s_r.tick_cnt + 6'h01;
          end
        end
      end
      lamp_seq_pkg::ST_BOOST: begin
        if (temp_boost_end_i) begin
          s_nxt.st = lamp_seq_pkg::ST_TRANS;
          s_nxt.tick_cnt = 6'h00;
          s_nxt.boost_cnt = 6'h00;
        end else if (cb_tick_i) begin
          if (s_r.boost_cnt + 6'h01 == lamp_seq_pkg::BOOST_PULSES) begin
            s_nxt.st = lamp_seq_pkg::ST_TRANS;
            s_nxt.tick_cnt = 6'h00;
            s_nxt.boost_cnt = 6'h00;
          end else begin
            s_nxt.boost_cnt = s_r.boost_cnt + 6'h01;
          end
        end
      end
      lamp_seq_pkg::ST_TRANS: begin
        // ratio falls from 15 to 0 across the 32 preheat-timer ticks
        if (cp_tick_i) begin
          if (s_r.tick_cnt + 6'h01 == lamp_seq_pkg::TRANS_PULSES) begin
            s_nxt.st = lamp_seq_pkg::ST_BURN;
            s_nxt.ratio = 4'h0;
            s_nxt.tick_cnt = 6'h00;
          end else begin
            s_nxt.tick_cnt = s_r.tick_cnt + 6'h01;
            s_nxt.ratio = lamp_seq_pkg::RATIO_STEPS - 4'(ratio_drop);
          end
        end
      end
      lamp_seq_pkg::ST_BURN: begin
        s_nxt.ratio = 4'h0;
      end
      lamp_seq_pkg::ST_HOLD: begin
        // failed ignition waits for the ramp top before the retention discharge
        if (s_r.wait_top) begin
          if (cp_top_i) begin
            s_nxt.wait_top = 1'b0;
          end
        end else if (cp_release_i) begin
          s_nxt.st = lamp_seq_pkg::ST_STARTUP;
        end
      end
      lamp_seq_pkg::ST_PWRDN: begin
        s_nxt.osc_run = 1'b0;
      end
    endcase
    // overcurrent timer: two preheat-ramp edges in a row exceed half a preheat-timer tick
    if (s_r.st == lamp_seq_pkg::ST_BOOST || s_r.st == lamp_seq_pkg::ST_BURN) begin
      if (!overcurrent_i) begin
        s_nxt.oc_cnt = 2'h0;
      end else if (cp_tick_i || cp_top_i) begin
        s_nxt.oc_cnt = s_r.oc_cnt + 2'h1;
        if (s_r.oc_cnt + 2'h1 == lamp_seq_pkg::OC_EDGES) begin
          s_nxt.st = lamp_seq_pkg::ST_PWRDN;
        end
      end
    end else begin
      s_nxt.oc_cnt = 2'h0;
    end
    // counters of the boost sequence never leak into a later boost
    if (s_nxt.st != lamp_seq_pkg::ST_BOOST && s_nxt.st != lamp_seq_pkg::ST_TRANS) begin
      s_nxt.boost_cnt = 6'h00;
    end
    // hold: latch, stop oscillator, restart later from maximum frequency
    if (s_nxt.st == lamp_seq_pkg::ST_HOLD || s_nxt.st == lamp_seq_pkg::ST_PWRDN) begin
      s_nxt.osc_run = 1'b0;
      s_nxt.saw_cnt = 16'h0000;
      s_nxt.phase = 1'b0;
    end
    if (s_nxt.st == lamp_seq_pkg::ST_HOLD) begin
      s_nxt.hold_latch = 1'b1;
    end
    // gate drive: each switch waits the dead time into its own half
    if (s_nxt.st == lamp_seq_pkg::ST_PWRDN) begin
      s_nxt.hs = 1'b0;
      s_nxt.ls = 1'b0;
    end else if (!s_nxt.osc_run) begin
      s_nxt.hs = 1'b0;
      s_nxt.ls = 1'b1;
    end else begin
      s_nxt.hs = s_nxt.phase & (s_nxt.saw_cnt >= lamp_seq_pkg::DEAD_CYC);
      s_nxt.ls = ~s_nxt.phase & (s_nxt.saw_cnt >= lamp_seq_pkg::DEAD_CYC);
    end
    // address phase: capture write target, latch read data, status from current values, control and period from next values
    if (bus_req) begin
      s_nxt.wr_pend = hwrite_i;
      s_nxt.wr_addr = haddr_i[7:0];
      s_nxt.rdata = 32'h0000_0000;
      if (!hwrite_i) begin
        if (haddr_i[7:0] == lamp_seq_pkg::ADDR_STATUS) begin
          s_nxt.rdata[lamp_seq_pkg::STAT_STATE_LSB +: 8] = s_r.st;
          s_nxt.rdata[lamp_seq_pkg::STAT_ATT_LSB +: 2] = s_r.attempts;
          s_nxt.rdata[lamp_seq_pkg::STAT_BCNT_LSB +: 6] = s_r.boost_cnt;
          s_nxt.rdata[lamp_seq_pkg::STAT_RATIO_LSB +: 4] = s_r.ratio;
          s_nxt.rdata[lamp_seq_pkg::STAT_DIM_LSB +: 2] = s_r.dim;
          s_nxt.rdata[lamp_seq_pkg::STAT_HOLD_BIT] = s_r.hold_latch;
        end else if (haddr_i[7:0] == lamp_seq_pkg::ADDR_CTRL) begin
          s_nxt.rdata[lamp_seq_pkg::CTRL_RUN_BIT] = s_nxt.run_en;
        end else if (haddr_i[7:0] == lamp_seq_pkg::ADDR_PERIOD) begin
          s_nxt.rdata[15:0] = s_nxt.min_period;
        end
      end
    end
  end

  // state register; undervoltage reset clears latch and counters
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '{st: lamp_seq_pkg::ST_STARTUP, run_en: lamp_seq_pkg::CTRL_RUN_RST,
               min_period: lamp_seq_pkg::PERIOD_RST, period: lamp_seq_pkg::PERIOD_RST,
               default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs from the state record, except preheat_timer_run_o also takes overcurrent_i
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = s_r.rdata;
  assign high_side_switch_o = s_r.hs;
  assign low_side_switch_o = s_r.ls;
  assign osc_running_o = s_r.osc_run;
  assign boost_ratio_o = s_r.ratio;
  assign dim_level_o = s_r.dim;
  assign boost_cap_discharge_o = (s_r.st != lamp_seq_pkg::ST_BOOST);
  assign preheat_timer_run_o = (s_r.st == lamp_seq_pkg::ST_PREHEAT)
                             | (s_r.st == lamp_seq_pkg::ST_IGNITE)
                             | (s_r.st == lamp_seq_pkg::ST_TRANS)
                             | (s_r.oc_cnt != 2'h0) | ((s_r.st == lamp_seq_pkg::ST_BOOST
                             | s_r.st == lamp_seq_pkg::ST_BURN) & overcurrent_i);
  assign preheat_cap_discharge_o = (s_r.st == lamp_seq_pkg::ST_HOLD) & ~s_r.wait_top;
  // sensing stays on from ignition through burn, off in preheat
  assign lamp_sense_en_o = (s_r.st == lamp_seq_pkg::ST_IGNITE) | (s_r.st == lamp_seq_pkg::ST_BOOST)
                         | (s_r.st == lamp_seq_pkg::ST_TRANS) | (s_r.st == lamp_seq_pkg::ST_BURN);
  assign hold_latch_o = s_r.hold_latch;
  assign power_down_o = (s_r.st == lamp_seq_pkg::ST_PWRDN);

  // checks on the sequencing
  sequence s_ignite_ok;
    s_r.st == lamp_seq_pkg::ST_IGNITE && !vdd_below_stop_i && lamp_ignited_i;
  endsequence
  sequence s_ign_timeout;
    s_r.st == lamp_seq_pkg::ST_IGNITE && !vdd_below_stop_i && !lamp_ignited_i && cp_tick_i
      && s_r.tick_cnt[1:0] == 2'h1;
  endsequence

  a_ignite_boost: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_ignite_ok ##0 boost_ok |=> s_r.st == lamp_seq_pkg::ST_BOOST && s_r.ratio == 4'hf)
    else $error("ignition did not enter boost at full ratio");
  a_bypass_burn: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_ignite_ok ##0 !boost_ok |=> s_r.st == lamp_seq_pkg::ST_BURN && s_r.ratio == 4'h0)
    else $error("bypassed boost did not go to burn");
  a_boost_length: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_r.st == lamp_seq_pkg::ST_BOOST && cb_tick_i && s_r.boost_cnt == 6'h3e
      && !temp_boost_end_i && !overcurrent_i |=> s_r.st == lamp_seq_pkg::ST_TRANS)
    else $error("boost did not end after 63 pulses");
  a_temp_cut: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_r.st == lamp_seq_pkg::ST_BOOST && temp_boost_end_i && !overcurrent_i
      |=> s_r.st == lamp_seq_pkg::ST_TRANS && s_r.tick_cnt == 6'h00)
    else $error("boost end temperature did not start transition");
  a_trans_end: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_r.st == lamp_seq_pkg::ST_TRANS && cp_tick_i && s_r.tick_cnt == 6'h1f
      |=> s_r.st == lamp_seq_pkg::ST_BURN && s_r.ratio == 4'h0 && s_r.boost_cnt == 6'h00)
    else $error("transition did not end after 32 ticks");
  a_stop_no_count: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (s_r.st == lamp_seq_pkg::ST_PREHEAT || s_r.st == lamp_seq_pkg::ST_IGNITE) && vdd_below_stop_i
      |=> s_r.st == lamp_seq_pkg::ST_HOLD && s_r.attempts == $past(s_r.attempts) && !s_r.wait_top)
    else $error("supply stop mishandled");
  a_fail_retry: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_ign_timeout |=> (s_r.st == lamp_seq_pkg::ST_PWRDN) == ($past(s_r.attempts) == 2'h1)
      && (s_r.st == lamp_seq_pkg::ST_PWRDN || s_r.wait_top))
    else $error("failed ignition handling wrong");
  a_hold_drive: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_r.st == lamp_seq_pkg::ST_HOLD |-> s_r.ls && !s_r.hs && !s_r.osc_run && s_r.hold_latch)
    else $error("hold drive wrong");
  a_dead_time: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $rose(s_r.hs) |-> !s_r.ls && !$past(s_r.ls) && s_r.saw_cnt == lamp_seq_pkg::DEAD_CYC)
    else $error("high side turned on without dead time");
endmodule // lamp_seq
`default_nettype wire

// ### bench/bridge_tank_model.sv
// behavioural half-bridge switches and lamp resonant tank
// assumes active-high gate drives and the sequencer's single clock
`timescale 1ns/1ps
`default_nettype none
module bridge_tank_model #(
  parameter int IGN_EDGES = 2
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic hs_i,
  input wire logic ls_i,
  input wire logic osc_i,
  input wire logic ign_en_i,
  input wire logic oc_en_i,
  output logic lamp_ignited_o,
  output logic current_high_o,
  output logic overcurrent_o,
  output logic shoot_through_o
);
  logic hs_q;
  logic [3:0] edges;
  // lamp strikes only after real bridge periods; it dies once the bridge stops
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hs_q <= 1'b0;
      edges <= 4'h0;
      shoot_through_o <= 1'b0;
    end else begin
      hs_q <= hs_i;
      if (!osc_i) edges <= 4'h0;
      else if (hs_i && !hs_q && edges != 4'hf) edges <= edges + 4'h1;
      // sticky, so a single overlap cycle is never missed
      if (hs_i && ls_i) shoot_through_o <= 1'b1;
    end
  end
  // tank current follows the high-side phase so the loop is steered both ways
  assign lamp_ignited_o = ign_en_i && osc_i && (edges >= 4'(IGN_EDGES));
  assign current_high_o = lamp_ignited_o && hs_i;
  assign overcurrent_o = oc_en_i && lamp_ignited_o;
endmodule // bridge_tank_model
`default_nettype wire

// ### bench/tb.sv
// self-checking bench of the lamp sequencer: bus tasks, tick pulses, state checks
// assumes lamp_seq, lamp_seq_pkg and bridge_tank_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [7:0] S_UP = lamp_seq_pkg::ST_STARTUP;
  localparam logic [7:0] S_PRE = lamp_seq_pkg::ST_PREHEAT;
  localparam logic [7:0] S_IGN = lamp_seq_pkg::ST_IGNITE;
  localparam logic [7:0] S_BST = lamp_seq_pkg::ST_BOOST;
  localparam logic [7:0] S_TRN = lamp_seq_pkg::ST_TRANS;
  localparam logic [7:0] S_BRN = lamp_seq_pkg::ST_BURN;
  localparam logic [7:0] A_ST = lamp_seq_pkg::ADDR_STATUS;
  localparam logic [7:0] A_CT = lamp_seq_pkg::ADDR_CTRL;
  localparam logic [7:0] A_PD = lamp_seq_pkg::ADDR_PERIOD;
  logic clock_i = 1'b0, rst_n_i = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0, dim_mem = 2'h0, diml;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrd, q;
  logic [4:0] pl = 5'h0;
  logic vs = 1'b0, cmax = 1'b0, cret = 1'b0, cbs = 1'b0, tby = 1'b0, tbe = 1'b0;
  logic ign_en = 1'b0, oc_en = 1'b0;
  logic hrdy, hresp, hs, ls, osc, cbd, ptr, pcd, sen, hl, pd, lamp, cur, oc, sht;
  logic [3:0] ratio;
  int err_total = 0, n_checks = 0;
  // 40 MHz clock
  always #12.5 clock_i = ~clock_i;
  // single slave, so its ready is the bus ready
  lamp_seq uut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy),
    .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrd), .vdd_start_i(vs),
    .vdd_below_stop_i(pl[4]), .cp_above_max_i(cmax), .cp_top_i(pl[2]), .cp_tick_i(pl[0]),
    .cp_release_i(pl[3]), .cp_retain_i(cret), .dim_memory_i(dim_mem), .cb_tick_i(pl[1]),
    .cb_short_i(cbs), .lamp_ignited_i(lamp), .temp_bypass_i(tby), .temp_boost_end_i(tbe),
    .overcurrent_i(oc), .current_high_i(cur), .high_side_switch_o(hs),
    .low_side_switch_o(ls), .osc_running_o(osc), .boost_ratio_o(ratio),
    .dim_level_o(diml), .boost_cap_discharge_o(cbd), .preheat_timer_run_o(ptr),
    .preheat_cap_discharge_o(pcd), .lamp_sense_en_o(sen), .hold_latch_o(hl),
    .power_down_o(pd));
  bridge_tank_model #(.IGN_EDGES(2)) tank (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .hs_i(hs), .ls_i(ls), .osc_i(osc),
    .ign_en_i(ign_en), .oc_en_i(oc_en), .lamp_ignited_o(lamp), .current_high_o(cur),
    .overcurrent_o(oc), .shoot_through_o(sht));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // waits for ready at a rising edge; only the watchdog ends a stuck wait
  task automatic wait_rdy();
    do begin
      @(posedge clock_i);
    end while (hrdy !== 1'b1);
  endtask
  // one single word transfer: address phase, then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    r = hrd;
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic cs(input logic [7:0] e);
    logic [31:0] r;
    ahb(1'b0, A_ST, 32'h0, r);
    chk({24'h0, r[7:0]}, {24'h0, e});
  endtask
  // one-cycle pulse on a ramp or supply line: 0 cp tick, 1 cb tick, 2 top, 3 release, 4 stop
  task automatic pulse(input int b, input int n);
    repeat (n) begin
      pl[b] <= 1'b1;
      @(posedge clock_i);
      pl <= 5'h0;
      @(posedge clock_i);
    end
  endtask
  task automatic do_reset(input logic [1:0] dm, input logic rt);
    rst_n_i <= 1'b0;
    {vs, cmax, cbs, tby, tbe, ign_en, oc_en} <= 7'h0;
    pl <= 5'h0;
    dim_mem <= dm;
    cret <= rt;
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clock_i);
  endtask
  task automatic to_ign();
    vs <= 1'b1;
    cmax <= 1'b1;
    repeat (3) @(posedge clock_i);
    cs(S_PRE);
    pulse(0, 7);
    cs(S_PRE);
    pulse(0, 1);
    cs(S_IGN);
  endtask
  task automatic ignite();
    ign_en <= 1'b1;
    // strike takes a few bridge periods; the watchdog bounds this wait
    do begin
      @(posedge clock_i);
    end while (lamp !== 1'b1);
    repeat (2) @(posedge clock_i);
  endtask
  // main sequence
  initial begin
    do_reset(2'h2, 1'b0);
    ahb(1'b0, A_ST, 32'h0, q);
    chk(q, 32'h00000001);
    chk({30'h0, hs, ls}, 32'h1);
    ahb(1'b0, A_CT, 32'h0, q);
    chk(q, 32'h1);
    ahb(1'b1, A_PD, 32'h00000050, q);
    ahb(1'b0, A_PD, 32'h0, q);
    chk(q, 32'h00000050);
    ahb(1'b1, 8'h0c, 32'hffffffff, q);
    ahb(1'b0, 8'h0c, 32'h0, q);
    chk(q, 32'h0);
    ahb(1'b1, A_PD, 32'h00000064, q);
    ahb(1'b1, A_CT, 32'h0, q);
    vs <= 1'b1;
    repeat (4) @(posedge clock_i);
    chk({31'h0, osc}, 32'h0);
    ahb(1'b1, A_CT, 32'h1, q);
    repeat (4) @(posedge clock_i);
    chk({31'h0, osc}, 32'h1);
    $display("test registers done");
    do_reset(2'h0, 1'b0);
    to_ign();
    ignite();
    cs(S_BST);
    chk({28'h0, ratio, cbd}, 32'h1e);
    pulse(1, 62);
    ahb(1'b0, A_ST, 32'h0, q);
    chk({16'h0, q[15:0]}, 32'h0000f808);
    pulse(1, 1);
    cs(S_TRN);
    pulse(0, 16);
    chk({27'h0, ratio, ptr}, 32'h11);
    pulse(0, 15);
    cs(S_TRN);
    pulse(0, 1);
    ahb(1'b0, A_ST, 32'h0, q);
    chk(q, 32'h00000020);
    chk({30'h0, sen, cbd}, 32'h3);
    oc_en <= 1'b1;
    pulse(0, 1);
    cs(S_BRN);
    pulse(0, 1);
    chk({29'h0, pd, hs, ls}, 32'h4);
    chk({31'h0, sht}, 32'h0);
    $display("test boost path done");
    for (int i = 0; i < 4; i++) begin
      do_reset((i == 0) ? 2'h2 : 2'h0, i == 0);
      tby <= (i == 1);
      cbs <= (i == 2);
      to_ign();
      ignite();
      cs((i == 3) ? S_BST : S_BRN);
      chk({30'h0, diml}, (i == 0) ? 32'h2 : 32'h0);
    end
    tbe <= 1'b1;
    repeat (2) @(posedge clock_i);
    cs(S_TRN);
    $display("test bypass done");
    do_reset(2'h0, 1'b0);
    for (int i = 0; i < 2; i++) begin
      vs <= 1'b1;
      cmax <= 1'b1;
      repeat (3) @(posedge clock_i);
      cs(S_PRE);
      pulse(4, 1);
      ahb(1'b0, A_ST, 32'h0, q);
      chk(q, 32'h00400040);
      chk({27'h0, hs, ls, osc, pcd, hl}, 32'hb);
      cmax <= 1'b0;
      pulse(3, 1);
      cs(S_UP);
    end
    $display("test supply hold done");
    do_reset(2'h0, 1'b0);
    for (int i = 0; i < 2; i++) begin
      to_ign();
      pulse(0, 1);
      cs(S_IGN);
      pulse(0, 1);
      ahb(1'b0, A_ST, 32'h0, q);
      chk({16'h0, q[15:0]}, (i == 0) ? 32'h0140 : 32'h0280);
      if (i == 0) begin
        chk({31'h0, pcd}, 32'h0);
        pulse(2, 1);
        chk({31'h0, pcd}, 32'h1);
        cmax <= 1'b0;
        pulse(3, 1);
        cs(S_UP);
      end
    end
    chk({29'h0, pd, hs, ls}, 32'h4);
    $display("test ignition retry done");
    final_report();
  end
  // watchdog well beyond the expected run length
  initial begin
    repeat (80000) @(posedge clock_i);
    err_total++;
    final_report();
  end
endmodule // tb
`default_nettype wire
